// ---- rtl/int_prio_pkg.sv ----
// constants for the upper interrupt priority register bank
package int_prio_pkg;
  // bus and register geometry
  localparam int DATA_W = 32; // bus data width
  localparam int REG_W = 16; // implemented register width
  localparam int NUM_REGS = 6; // registers in the bank
  localparam int NUM_FIELDS = 20; // priority fields in the bank
  localparam int FIELD_W = 3; // width of one priority field
  // byte offsets of the registers, one aligned word each
  localparam logic [11:0] OFF_PRIO_CTRL_10 = 12'h000;
  localparam logic [11:0] OFF_PRIO_CTRL_11 = 12'h004;
  localparam logic [11:0] OFF_PRIO_CTRL_12 = 12'h008;
  localparam logic [11:0] OFF_PRIO_CTRL_13 = 12'h00c;
  localparam logic [11:0] OFF_PRIO_CTRL_14 = 12'h010;
  localparam logic [11:0] OFF_PRIO_CTRL_15 = 12'h014;
  // register indices
  localparam logic [2:0] IDX_10 = 3'h0;
  localparam logic [2:0] IDX_11 = 3'h1;
  localparam logic [2:0] IDX_12 = 3'h2;
  localparam logic [2:0] IDX_13 = 3'h3;
  localparam logic [2:0] IDX_14 = 3'h4;
  localparam logic [2:0] IDX_15 = 3'h5;
  // implemented bits of each register, the rest read zero
  localparam logic [15:0] IMPL_MASK [NUM_REGS] = '{
    16'h7777, 16'h7707, 16'h7777, 16'h7777, 16'h0777, 16'h7070};
  // field reset pattern: top bit set, level four
  localparam logic [2:0] FIELD_RESET = 3'h4;
  // field levels with meaning
  localparam logic [2:0] LEVEL_OFF = 3'h0; // source disabled
  localparam logic [2:0] LEVEL_MAX = 3'h7; // highest user level
  // register holding each field, in field order
  localparam logic [2:0] FIELD_REG [NUM_FIELDS] = '{
    IDX_10, IDX_10, IDX_10, IDX_10,
    IDX_11, IDX_11, IDX_11,
    IDX_12, IDX_12, IDX_12, IDX_12,
    IDX_13, IDX_13, IDX_13, IDX_13,
    IDX_14, IDX_14, IDX_14,
    IDX_15, IDX_15};
  // low bit of each field inside its register
  localparam logic [3:0] FIELD_LSB [NUM_FIELDS] = '{
    4'hc, 4'h8, 4'h4, 4'h0,
    4'hc, 4'h8, 4'h0,
    4'hc, 4'h8, 4'h4, 4'h0,
    4'hc, 4'h8, 4'h4, 4'h0,
    4'h8, 4'h4, 4'h0,
    4'hc, 4'h4};
  // ahb transfer type and response codes
  localparam logic [1:0] HTRANS_IDLE = 2'h0;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic HRESP_OKAY = 1'b0;
endpackage : int_prio_pkg

// ---- rtl/prio_field.sv ----
// one 3-bit priority field with its enabled flag
`timescale 1ns/1ps
module prio_field
  import int_prio_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic wrEn,
  input wire logic [2:0] wrData,
  output logic [2:0] level,
  output logic enabled
);

  // stored level; reset gives level four
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      level <= FIELD_RESET;
    end else if (wrEn) begin
      level <= wrData;
    end
  end

  // enabled flag kept in step with the level, so the
  // arbiter sees a clean registered qualifier
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      enabled <= 1'b1;
    end else if (wrEn) begin
      // zero level means the source is never offered
      enabled <= (wrData != LEVEL_OFF);
    end
  end

endmodule : prio_field

// ---- rtl/int_prio_regs.sv ----
// ahb-lite register bank of upper interrupt priority fields
//
// Contract
// - fields are unsigned levels, one through seven
// - level zero disables the source entirely
// - bits without a field read as zero
// - every field resets to pattern 100
// - fields read back the last written value
// - register 10 holds compare7/6/5 and capture6
// - register 11 holds timer6, channel4, compare8
// - register 12 holds timer8, twowire2 pair, timer7
// - register 13 holds can2 receive, irq4/3, timer9
// - register 14 holds encoder, pulse width, can2
// - register 15 holds fault a, channel5
`timescale 1ns/1ps
module int_prio_regs
  import int_prio_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  // ahb-lite slave port
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // priority levels towards the arbiter
  output logic [2:0] out_compare7_priority,
  output logic [2:0] out_compare6_priority,
  output logic [2:0] out_compare5_priority,
  output logic [2:0] in_capture6_priority,
  output logic [2:0] timer6_priority,
  output logic [2:0] xfer_chan4_done_priority,
  output logic [2:0] out_compare8_priority,
  output logic [2:0] timer8_priority,
  output logic [2:0] twowire2_master_priority,
  output logic [2:0] twowire2_slave_priority,
  output logic [2:0] timer7_priority,
  output logic [2:0] can2_receive_priority,
  output logic [2:0] ext_irq4_priority,
  output logic [2:0] ext_irq3_priority,
  output logic [2:0] timer9_priority,
  output logic [2:0] quad_encoder_priority,
  output logic [2:0] pulse_width_priority,
  output logic [2:0] can2_event_priority,
  output logic [2:0] fault_a_priority,
  output logic [2:0] xfer_chan5_done_priority,
  // one flag per source, low when its level is zero
  output logic [19:0] sourceEnabled
);

  // field storage as seen by the bus logic
  logic [2:0] fieldLevel [NUM_FIELDS]; // levels in field order
  logic [NUM_FIELDS-1:0] fieldWrEn; // per field write strobe

  // address phase decode results
  logic addrTaken; // a transfer is accepted this edge
  logic addrHit; // address lands on a register
  logic [2:0] addrIdx; // register index of the address

  // data phase state captured at the address phase
  logic wrPend; // write data phase in progress
  logic rdPend; // read wait state in progress
  logic [2:0] wrIdx; // register being written
  logic [2:0] rdIdx; // register being read
  logic rdHit; // read targets a mapped register

  // readback of the register under read
  logic [15:0] rdValue; // masked register image

  // a transfer counts only when selected, non-idle and the
  // bus is ready; busy and seq are not used by this master
  assign addrTaken = hsel && htrans[1] && hready;

  // address decode: word offsets within the bank
  always_comb begin
    addrHit = 1'b1;
    addrIdx = IDX_10;
    if (haddr[11:0] == OFF_PRIO_CTRL_10) begin
      addrIdx = IDX_10;
    end else if (haddr[11:0] == OFF_PRIO_CTRL_11) begin
      addrIdx = IDX_11;
    end else if (haddr[11:0] == OFF_PRIO_CTRL_12) begin
      addrIdx = IDX_12;
    end else if (haddr[11:0] == OFF_PRIO_CTRL_13) begin
      addrIdx = IDX_13;
    end else if (haddr[11:0] == OFF_PRIO_CTRL_14) begin
      addrIdx = IDX_14;
    end else if (haddr[11:0] == OFF_PRIO_CTRL_15) begin
      addrIdx = IDX_15;
    end else begin
      // unmapped: writes dropped, reads give zero
      addrHit = 1'b0;
    end
  end

  // write capture; data arrives one cycle later on hwdata
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      wrPend <= 1'b0;
      wrIdx <= IDX_10;
    end else if (hready) begin
      // a new address phase replaces the old data phase
      wrPend <= addrTaken && hwrite && addrHit;
      wrIdx <= addrIdx;
    end
  end

  // read capture; the read always takes one wait state so
  // that a write in its data phase lands before sampling
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rdPend <= 1'b0;
      rdIdx <= IDX_10;
      rdHit <= 1'b0;
    end else if (addrTaken && !hwrite) begin
      rdPend <= 1'b1;
      rdIdx <= addrIdx;
      rdHit <= addrHit;
    end else begin
      rdPend <= 1'b0;
    end
  end

  // ready: low for the single read wait cycle only
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      hreadyout <= 1'b1;
    end else if (addrTaken && !hwrite) begin
      hreadyout <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
    end
  end

  // response is always okay; the bank never errors
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      hresp <= HRESP_OKAY;
    end else begin
      hresp <= HRESP_OKAY;
    end
  end

  // assemble the image of the register under read
  always_comb begin
    rdValue = 16'h0000;
    for (int f = 0; f < NUM_FIELDS; f++) begin
      if (FIELD_REG[f] == rdIdx) begin
        rdValue[FIELD_LSB[f] +: 3] = fieldLevel[f];
      end
    end
    // unimplemented bits forced low whatever the fields say
    rdValue = rdValue & IMPL_MASK[rdIdx];
  end

  // read data loaded at the end of the wait cycle
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      hrdata <= 32'h0000_0000;
    end else if (rdPend) begin
      // upper half and unmapped reads give zero
      hrdata <= rdHit ? {16'h0000, rdValue} : 32'h0000_0000;
    end
  end

  // one field cell per source; each picks its own lane of
  // the written word, so untouched lanes are never stored
  for (genvar f = 0; f < NUM_FIELDS; f++) begin : g_field
    assign fieldWrEn[f] = wrPend && (wrIdx == FIELD_REG[f]);
    prio_field u_field (
      .mclk(mclk),
      .rst(rst),
      .wrEn(fieldWrEn[f]),
      .wrData(hwdata[FIELD_LSB[f] +: 3]),
      .level(fieldLevel[f]),
      .enabled(sourceEnabled[f])
    );
  end

  // continuous field outputs, each straight from its cell
  assign out_compare7_priority = fieldLevel[0];
  assign out_compare6_priority = fieldLevel[1];
  assign out_compare5_priority = fieldLevel[2];
  assign in_capture6_priority = fieldLevel[3];
  assign timer6_priority = fieldLevel[4];
  assign xfer_chan4_done_priority = fieldLevel[5];
  assign out_compare8_priority = fieldLevel[6];
  assign timer8_priority = fieldLevel[7];
  assign twowire2_master_priority = fieldLevel[8];
  assign twowire2_slave_priority = fieldLevel[9];
  assign timer7_priority = fieldLevel[10];
  assign can2_receive_priority = fieldLevel[11];
  assign ext_irq4_priority = fieldLevel[12];
  assign ext_irq3_priority = fieldLevel[13];
  assign timer9_priority = fieldLevel[14];
  assign quad_encoder_priority = fieldLevel[15];
  assign pulse_width_priority = fieldLevel[16];
  assign can2_event_priority = fieldLevel[17];
  assign fault_a_priority = fieldLevel[18];
  assign xfer_chan5_done_priority = fieldLevel[19];

  // helper: read requests taken this cycle, by register
  logic rdTaken; // read address phase accepted
  assign rdTaken = addrTaken && !hwrite && addrHit;

  // checks on the bank behaviour
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);

  // fields come out of reset at level four
  property reset_level_p;
    @(posedge mclk) disable iff (1'b0)
    $past(rst) && !rst |-> fault_a_priority == FIELD_RESET &&
      timer9_priority == FIELD_RESET && sourceEnabled[18];
  endproperty
  reset_level_a: assert property (reset_level_p)
    else $error("field not at level four after reset");

  // register 10 write lands in the compare7 and capture6 lanes
  write_reg10_a: assert property (
    wrPend && wrIdx == IDX_10 |=>
      out_compare7_priority == $past(hwdata[14:12]) &&
      in_capture6_priority == $past(hwdata[2:0]))
    else $error("register 10 write not stored");

  // register 12 slave lane at bits 6-4
  write_reg12_a: assert property (
    wrPend && wrIdx == IDX_12 |=>
      twowire2_slave_priority == $past(hwdata[6:4]))
    else $error("register 12 slave lane wrong");

  // register 13 irq4 lane at bits 10-8
  write_reg13_a: assert property (
    wrPend && wrIdx == IDX_13 |=>
      ext_irq4_priority == $past(hwdata[10:8]) &&
      can2_receive_priority == $past(hwdata[14:12]))
    else $error("register 13 lanes wrong");

  // a zero level drops the enabled flag, any other raises it
  zero_disable_a: assert property (
    wrPend && wrIdx == IDX_14 |=>
      sourceEnabled[15] == ($past(hwdata[10:8]) != LEVEL_OFF) &&
      sourceEnabled[15] == (quad_encoder_priority != LEVEL_OFF))
    else $error("enabled flag disagrees with level");

  // writes elsewhere leave fields of other registers alone
  foreign_write_a: assert property (
    wrPend && wrIdx != IDX_15 |=> $stable(fault_a_priority))
    else $error("field changed by another register write");

  // a read waits exactly one cycle and returns the field
  read_back_a: assert property (
    rdTaken && addrIdx == IDX_11 |=> !hreadyout ##1
      hreadyout && hrdata[14:12] == timer6_priority &&
      hrdata[2:0] == out_compare8_priority)
    else $error("register 11 readback wrong");

  // unimplemented lanes of register 11 read zero
  read_gap11_a: assert property (
    rdTaken && addrIdx == IDX_11 |-> ##2 hrdata[7:3] == 5'h00)
    else $error("register 11 bits 7-3 not zero");

  // register 14 top bits read zero
  read_gap14_a: assert property (
    rdTaken && addrIdx == IDX_14 |-> ##2 hrdata[15:11] == 5'h00)
    else $error("register 14 bits 15-11 not zero");

  // register 15 holes at bits 11-7 and 3-0 read zero, channel5 field still visible
  read_gap15_a: assert property (
    rdTaken && addrIdx == IDX_15 |-> ##2
      hrdata[11:7] == 5'h00 && hrdata[3:0] == 4'h0 &&
      hrdata[6:4] == xfer_chan5_done_priority)
    else $error("register 15 readback wrong");

  // every read answer keeps the upper half and bits 15 and 3 clear
  read_mask_a: assert property (
    hreadyout && $past(rdPend) |->
      hrdata[31:16] == 16'h0000 && !hrdata[15] && !hrdata[3])
    else $error("reserved bits set in read data");

  // a stored top level stays a plain unsigned seven
  level_max_a: assert property (
    wrPend && wrIdx == IDX_12 && hwdata[2:0] == LEVEL_MAX |=>
      timer7_priority == LEVEL_MAX && sourceEnabled[10])
    else $error("level seven not kept");

  // main scenarios
  write_seen_c: cover property (wrPend && wrIdx == IDX_15);
  read_seen_c: cover property (rdTaken ##2 hreadyout);
  disable_seen_c: cover property (!sourceEnabled[0]);
  back_to_back_c: cover property (
    wrPend && wrIdx == IDX_10 && rdTaken && addrIdx == IDX_10);

endmodule : int_prio_regs

// ---- bench/testbench.sv ----
// self-checking bench for the upper interrupt priority register bank
`timescale 1ns/1ps
module testbench
  import int_prio_pkg::*;
  ;
  logic mclk; // 250 MHz system clock
  logic rst; // async reset, active high
  logic hsel; // bus select
  logic [31:0] haddr; // byte address
  logic [1:0] htrans; // transfer type
  logic hwrite; // high for writes
  logic [2:0] hsize; // always a whole word
  logic [31:0] hwdata; // write data
  logic hreadyout; // slave ready, also the bus ready
  logic hresp; // slave response
  logic [31:0] hrdata; // read data
  logic [2:0] lvl [NUM_FIELDS]; // levels in field order
  logic [19:0] sourceEnabled; // nonzero-level flags
  logic [31:0] rdData; // data seen at the end of a data phase
  logic rspSeen; // response seen with it
  int n_mismatch; // mismatches so far
  int tests_run; // comparisons so far
  // field placement kept apart from the rtl tables, so a wrong table shows
  localparam int REG_OF [20] = '{0, 0, 0, 0, 1, 1, 1, 2, 2, 2, 2,
    3, 3, 3, 3, 4, 4, 4, 5, 5};
  localparam int LSB_OF [20] = '{12, 8, 4, 0, 12, 8, 0, 12, 8, 4, 0,
    12, 8, 4, 0, 8, 4, 0, 12, 4};

  int_prio_regs dut (.mclk(mclk), .rst(rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .out_compare7_priority(lvl[0]),
    .out_compare6_priority(lvl[1]), .out_compare5_priority(lvl[2]),
    .in_capture6_priority(lvl[3]), .timer6_priority(lvl[4]),
    .xfer_chan4_done_priority(lvl[5]), .out_compare8_priority(lvl[6]),
    .timer8_priority(lvl[7]), .twowire2_master_priority(lvl[8]),
    .twowire2_slave_priority(lvl[9]), .timer7_priority(lvl[10]),
    .can2_receive_priority(lvl[11]), .ext_irq4_priority(lvl[12]),
    .ext_irq3_priority(lvl[13]), .timer9_priority(lvl[14]),
    .quad_encoder_priority(lvl[15]), .pulse_width_priority(lvl[16]),
    .can2_event_priority(lvl[17]), .fault_a_priority(lvl[18]),
    .xfer_chan5_done_priority(lvl[19]), .sourceEnabled(sourceEnabled));

  // free-running clock, 4 ns period
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  // word comparison, also used for flags and responses
  task automatic chk_word(input string what, input logic [31:0] exp,
    input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask : chk_word

  // level comparison on one field output
  task automatic chk_level(input string what, input logic [2:0] exp,
    input logic [2:0] got);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask : chk_level

  // level of field f in pattern k; 8 is the reset pattern, 9 all sevens
  function automatic logic [2:0] field_val(int f, int k);
    if (k == 8) return 3'h4;
    if (k == 9) return 3'h7;
    return 3'((f + k) % 8);
  endfunction : field_val

  // register word holding pattern k, zero outside the fields
  function automatic logic [31:0] field_word(int r, int k);
    logic [31:0] w;
    w = '0;
    for (int f = 0; f < NUM_FIELDS; f++) begin
      if (REG_OF[f] == r) w |= 32'(field_val(f, k)) << LSB_OF[f];
    end
    return w;
  endfunction : field_word

  // ride out one phase; sampled mid-cycle, where registered outputs stand
  task automatic wait_ready();
    logic rdy;
    do begin
      @(negedge mclk);
      rdy = hreadyout;
      rdData = hrdata;
      rspSeen = hresp;
      @(posedge mclk);
    end while (rdy !== 1'b1);
  endtask : wait_ready

  // single word write; entered just after a rising edge
  task automatic bus_write(input logic [31:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= HTRANS_NONSEQ;
    hwrite <= 1'b1;
    wait_ready();
    htrans <= HTRANS_IDLE;
    hwdata <= d;
    wait_ready();
  endtask : bus_write

  // single word read; the response must be okay every time
  task automatic bus_read(input logic [31:0] a, output logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= HTRANS_NONSEQ;
    hwrite <= 1'b0;
    wait_ready();
    htrans <= HTRANS_IDLE;
    wait_ready();
    d = rdData;
    chk_word("hresp", 32'(HRESP_OKAY), 32'(rspSeen));
  endtask : bus_read

  // every word and every level at the power-on pattern
  task automatic test_reset_values();
    logic [31:0] d;
    for (int r = 0; r < NUM_REGS; r++) begin
      bus_read(32'(4 * r), d);
      chk_word("reset word", field_word(r, 8), d);
    end
    for (int f = 0; f < NUM_FIELDS; f++) begin
      chk_level("reset level", 3'h4, lvl[f]);
    end
    chk_word("reset enables", 32'h000f_ffff, 32'(sourceEnabled));
  endtask : test_reset_values

  // pattern k into all fields, ones into every spare bit
  task automatic test_field_map(input int k);
    logic [31:0] d;
    for (int r = 0; r < NUM_REGS; r++) begin
      bus_write(32'(4 * r), field_word(r, k) | ~field_word(r, 9));
    end
    for (int r = 0; r < NUM_REGS; r++) begin
      bus_read(32'(4 * r), d);
      chk_word("readback", field_word(r, k), d);
    end
    for (int f = 0; f < NUM_FIELDS; f++) begin
      chk_level("level", field_val(f, k), lvl[f]);
      chk_word("enable", 32'(field_val(f, k) != 3'h0),
        32'(sourceEnabled[f]));
    end
  endtask : test_field_map

  // unmapped word is inert; a read right behind a write sees it
  // level one in every lane, so a write that aliased onto a
  // register would show against the all-sevens image left behind
  task automatic test_unmapped();
    logic [31:0] d;
    bus_write(32'h0000_0018, 32'h1111_1111);
    bus_read(32'h0000_0018, d);
    chk_word("unmapped read", 32'h0, d);
    for (int r = 0; r < NUM_REGS; r++) begin
      bus_read(32'(4 * r), d);
      chk_word("after unmapped", field_word(r, 9), d);
    end
    bus_write(32'h0000_0000, field_word(0, 5));
    bus_read(32'h0000_0000, d);
    chk_word("back to back", field_word(0, 5), d);
  endtask : test_unmapped

  // reset in mid-run drops every field back to level four
  task automatic test_mid_reset();
    rst <= 1'b1;
    repeat (2) @(posedge mclk);
    for (int f = 0; f < NUM_FIELDS; f++) begin
      chk_level("level in reset", 3'h4, lvl[f]);
    end
    rst <= 1'b0;
    @(posedge mclk);
    test_reset_values();
  endtask : test_mid_reset

  // single place where the run ends
  task automatic print_verdict();
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : print_verdict

  // main sequence: three cycles of reset, then the scenarios
  initial begin
    rst = 1'b1;
    hsel = 1'b0;
    haddr = '0;
    htrans = HTRANS_IDLE;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = '0;
    n_mismatch = 0;
    tests_run = 0;
    repeat (3) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    test_reset_values();
    test_field_map(0);
    test_field_map(3);
    test_field_map(9);
    test_unmapped();
    test_mid_reset();
    print_verdict();
  end

  // watchdog: the scenarios need well under a thousand cycles
  initial begin
    repeat (20000) @(posedge mclk);
    n_mismatch++;
    print_verdict();
  end
endmodule : testbench
